// file: common/uoca_pkg.sv
// shared constants, command/answer carriers and crc step for the
// user otp configuration array; assumes a 100 MHz ref_clk
package uoca_pkg;

   localparam int UOCA_DW = 16;
   localparam int UOCA_AW = 4;

   // array map, one word per address
   localparam logic [3:0] UOCA_ADDR_SERIAL = 4'h0;
   localparam logic [3:0] UOCA_ADDR_LOT    = 4'h1;
   localparam logic [3:0] UOCA_ADDR_FCFG   = 4'h2;
   localparam logic [3:0] UOCA_ADDR_FCRC   = 4'h3;
   localparam logic [3:0] UOCA_ADDR_UCFG2  = 4'h4;
   localparam logic [3:0] UOCA_ADDR_UCFG3  = 4'h5;
   localparam logic [3:0] UOCA_ADDR_UCRC   = 4'h6;
   localparam logic [3:0] UOCA_ADDR_STATUS = 4'h7;

   // factory words and their first values
   localparam int          UOCA_NUM_FAC      = 4;
   localparam int          UOCA_SERIAL_W     = 13;
   localparam logic [12:0] UOCA_SERIAL_FIRST = 13'h0001;
   localparam logic [15:0] UOCA_LOT_FIRST    = 16'h0001;
   localparam int          UOCA_RNG_W        = 3;
   localparam int          UOCA_FCFG_RNG_LSB = 0;
   localparam int          UOCA_FCFG_AXIS    = 4;

   // user words, index = address - UOCA_ADDR_UCFG2
   localparam int         UOCA_NUM_USER  = 3;
   localparam logic [1:0] UOCA_UIDX_CFG2 = 2'h0;
   localparam logic [1:0] UOCA_UIDX_CRC  = 2'h2;
   localparam int         UOCA_LOCK_BIT  = 15;

   // status word bits
   localparam int UOCA_STS_UERR_N = 0;
   localparam int UOCA_STS_FERR_N = 1;
   localparam int UOCA_STS_LOCKED = 2;
   localparam int UOCA_STS_BUSY   = 3;

   // crc-8 over each 16-bit word, msb first
   localparam int         UOCA_CRC_W    = 8;
   localparam logic [7:0] UOCA_CRC_POLY = 8'h07;
   localparam logic [7:0] UOCA_CRC_INIT = 8'hff;

   // otp burn time and its cycle count at 100 MHz
   localparam int UOCA_CLK_PERIOD_NS = 10;
   localparam int UOCA_BURN_TIME_NS  = 1000;
   localparam int UOCA_BURN_CYCLES   =
      (UOCA_BURN_TIME_NS + UOCA_CLK_PERIOD_NS - 1) / UOCA_CLK_PERIOD_NS;

   localparam int UOCA_SELFTEST_RETRY_LIMIT = 3;

   typedef enum logic [1:0] {
      UOCA_OP_NOP   = 2'h0,
      UOCA_OP_READ  = 2'h1,
      UOCA_OP_WRITE = 2'h2,
      UOCA_OP_EXEC  = 2'h3
   } uoca_op_e;

   typedef struct packed {
      logic          valid;
      uoca_op_e      op;
      logic [3:0]    addr;
      logic [15:0]   data;
   } uoca_cmd_s;

   typedef struct packed {
      logic          valid;
      logic          ok;
      logic [15:0]   data;
   } uoca_rsp_s;

   // gray along fchk-idle-burn-readout-uchk
   typedef enum logic [2:0] {
      UOCA_S_FCHK    = 3'h0,
      UOCA_S_IDLE    = 3'h1,
      UOCA_S_BURN    = 3'h3,
      UOCA_S_READOUT = 3'h2,
      UOCA_S_UCHK    = 3'h6
   } uoca_state_e;

   function automatic logic [7:0] uocaCrcStep(logic [7:0]  c,
                                              logic [15:0] w);
      logic [7:0] r;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         r = {r[6:0], 1'b0} ^ ((r[7] ^ w[i]) ? UOCA_CRC_POLY : 8'h00);
      end
      return r;
   endfunction

endpackage

// file: verilog/uoca_crc.sv
// running crc over a stream of array words
// assumes clear and feed never come in the same cycle
`timescale 1ns/1ps
module uoca_crc
   import uoca_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // word stream
   input  wire logic              clear,
   input  wire logic              feed,
   input  wire logic [15:0]       word,
   // result
   output logic [UOCA_CRC_W-1:0]  crc
);

   typedef struct packed {
      logic [UOCA_CRC_W-1:0] crc;
   } uoca_crc_state_s;

   uoca_crc_state_s s_d;
   uoca_crc_state_s s_q;

   always_comb begin
      s_d = s_q;
      if (clear) begin
         s_d.crc = UOCA_CRC_INIT;
      end else if (feed) begin
         s_d.crc = uocaCrcStep(s_q.crc, word);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{crc: UOCA_CRC_INIT};
      end else begin
         s_q <= s_d;
      end
   end

   assign crc = s_q.crc;

endmodule

// file: verilog/uoca_selftest_retry.sv
// self-test sequencer with bounded retries
// assumes the sensor reports one pass/fail per run request
`timescale 1ns/1ps
module uoca_selftest_retry
   import uoca_pkg::*;
#(
   parameter int SELFTEST_RETRY_LIMIT = UOCA_SELFTEST_RETRY_LIMIT
)
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // control from the sensor side
   input  wire logic start,
   input  wire logic resultValid,
   input  wire logic pass,
   // results
   output logic      run,
   output logic      retry,
   output logic      sensorError
);

   typedef struct packed {
      logic       run;
      logic       retry;
      logic       err;
      logic [7:0] tries;
   } uoca_st_state_s;

   uoca_st_state_s s_d;
   uoca_st_state_s s_q;

   always_comb begin
      s_d       = s_q;
      s_d.retry = 1'b0;
      if (start) begin
         s_d.run   = 1'b1;
         s_d.err   = 1'b0;
         s_d.tries = 8'h00;
      end else if (s_q.run && resultValid) begin
         if (pass) begin
            s_d.run = 1'b0;
         end else if (s_q.tries < 8'(SELFTEST_RETRY_LIMIT)) begin
            s_d.tries = s_q.tries + 8'h01;
            s_d.retry = 1'b1;
         end else begin
            // error message only once the retries are spent
            s_d.run = 1'b0;
            s_d.err = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign run         = s_q.run;
   assign retry       = s_q.retry;
   assign sensorError = s_q.err;

endmodule

// file: verilog/uoca_user_otp_config_array.sv
// user accessible otp configuration array: factory block, user block
// and read-only status, reached by commands decoded from the psi5 link
// assumes the psi5 receiver delivers one command per cycle at most
//
// Notes on behaviour
// - factory otp, user otp and status registers
// - separate crc checker for each otp block
// - only user words writable; factory never writable
// - serial starts at 1, 13-bit field
// - lot number starts at 1, sequential
// - serial and lot inside factory crc only
// - factory config read-only, factory crc covered
// - factory config holds axis bit, range code
// - user config word two is user otp
// - locked array refuses user writes
// - lock bit burned with rest on execute
// - after burn: readout, then lock and user crc check only if lock bit burned
// - self-test retries to limit, then error
// - user crc mismatch clears flag until reset
`timescale 1ns/1ps
module uoca_user_otp_config_array
   import uoca_pkg::*;
#(
   parameter logic [12:0] FACTORY_SERIAL = UOCA_SERIAL_FIRST,
   parameter logic [15:0] FACTORY_LOT    = UOCA_LOT_FIRST,
   parameter logic        FACTORY_AXIS   = 1'b0,
   parameter logic [2:0]  FACTORY_RANGE  = 3'h0,
   parameter int          SELFTEST_RETRY_LIMIT =
      UOCA_SELFTEST_RETRY_LIMIT,
   parameter int          BURN_CYCLES    = UOCA_BURN_CYCLES
)
(
   // clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rst_b,
   // decoded psi5 commands and their answers
   input  wire uoca_cmd_s       cmd,
   output uoca_rsp_s            rsp,
   // status
   output logic                 userOtpErrorFlagN,
   output logic                 factoryErrorFlagN,
   output logic                 arrayLocked,
   output logic                 busy,
   // factory device properties
   output logic                 axisIndicator,
   output logic [2:0]           fullScaleRangeCode,
   // self-test
   input  wire logic            selftestStart,
   input  wire logic            selftestResultValid,
   input  wire logic            selftestPass,
   output logic                 selftestRun,
   output logic                 selftestRetry,
   output logic                 sensorErrorMsg
);

   localparam logic [15:0] FAC_SERIAL_WORD = {
      {(UOCA_DW - UOCA_SERIAL_W){1'b0}}, FACTORY_SERIAL};
   localparam logic [15:0] FAC_CFG_WORD =
      (16'(FACTORY_AXIS) << UOCA_FCFG_AXIS) |
      (16'(FACTORY_RANGE) << UOCA_FCFG_RNG_LSB);
   // factory crc covers serial, lot and config words
   localparam logic [7:0] FAC_CRC = uocaCrcStep(uocaCrcStep(
      uocaCrcStep(UOCA_CRC_INIT, FAC_SERIAL_WORD), FACTORY_LOT),
      FAC_CFG_WORD);
   localparam logic [15:0] FAC_CRC_WORD = {8'h00, FAC_CRC};
   localparam logic [15:0] BURN_LAST = 16'(BURN_CYCLES - 1);

   typedef struct packed {
      uoca_state_e                         st;
      logic [UOCA_NUM_FAC-1:0][15:0]       fac;
      logic [UOCA_NUM_USER-1:0][15:0]      shadow;
      logic [UOCA_NUM_USER-1:0][15:0]      otp;
      logic                                locked;
      logic                                uErrN;
      logic                                fErrN;
      logic                                busy;
      logic [1:0]                          idx;
      logic [15:0]                         cnt;
      uoca_rsp_s                           rsp;
   } uoca_state_s;

   uoca_state_s              s_d;
   uoca_state_s              s_q;
   logic                     fFeed;
   logic [15:0]              fWord;
   logic                     fClear;
   logic [UOCA_CRC_W-1:0]    fCrc;
   logic                     uFeed;
   logic [15:0]              uWord;
   logic                     uClear;
   logic [UOCA_CRC_W-1:0]    uCrc;
   logic [1:0]               uIdx;
   logic [15:0]              stsWord;

   function automatic logic isUserAddr(logic [3:0] a);
      return (a >= UOCA_ADDR_UCFG2) && (a <= UOCA_ADDR_UCRC);
   endfunction

   function automatic logic isFacAddr(logic [3:0] a);
      return a <= UOCA_ADDR_FCRC;
   endfunction

   // independent checkers, one per otp block
   uoca_crc u_fac_crc (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .clear   (fClear),
      .feed    (fFeed),
      .word    (fWord),
      .crc     (fCrc)
   );

   uoca_crc u_user_crc (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .clear   (uClear),
      .feed    (uFeed),
      .word    (uWord),
      .crc     (uCrc)
   );

   uoca_selftest_retry #(
      .SELFTEST_RETRY_LIMIT (SELFTEST_RETRY_LIMIT)
   ) u_selftest (
      .ref_clk     (ref_clk),
      .rst_b       (rst_b),
      .start       (selftestStart),
      .resultValid (selftestResultValid),
      .pass        (selftestPass),
      .run         (selftestRun),
      .retry       (selftestRetry),
      .sensorError (sensorErrorMsg)
   );

   always_comb begin
      stsWord                  = 16'h0000;
      stsWord[UOCA_STS_UERR_N] = s_q.uErrN;
      stsWord[UOCA_STS_FERR_N] = s_q.fErrN;
      stsWord[UOCA_STS_LOCKED] = s_q.locked;
      stsWord[UOCA_STS_BUSY]   = s_q.busy;
      uIdx = 2'(cmd.addr - UOCA_ADDR_UCFG2);
   end

   always_comb begin
      s_d     = s_q;
      s_d.rsp = '0;
      fFeed   = 1'b0;
      fWord   = 16'h0000;
      fClear  = 1'b0;
      uFeed   = 1'b0;
      uWord   = 16'h0000;
      uClear  = 1'b0;

      unique case (s_q.st)
         UOCA_S_FCHK: begin
            if (s_q.idx < 2'h3) begin
               fFeed   = 1'b1;
               fWord   = s_q.fac[s_q.idx];
               s_d.idx = s_q.idx + 2'h1;
            end else begin
               if (fCrc != s_q.fac[UOCA_NUM_FAC-1][7:0]) begin
                  s_d.fErrN = 1'b0;
               end
               s_d.st = UOCA_S_IDLE;
            end
         end
         UOCA_S_IDLE: begin
            // keeps the factory checker parked at its seed
            fClear = 1'b1;
         end
         UOCA_S_BURN: begin
            if (s_q.cnt == BURN_LAST) begin
               // otp bits only ever go from 0 to 1
               s_d.otp = s_q.otp | s_q.shadow;
               s_d.st  = UOCA_S_READOUT;
            end else begin
               s_d.cnt = s_q.cnt + 16'h0001;
            end
         end
         UOCA_S_READOUT: begin
            s_d.shadow = s_q.otp;
            s_d.locked =
               s_q.otp[UOCA_UIDX_CFG2][UOCA_LOCK_BIT];
            uClear     = 1'b1;
            s_d.idx    = 2'h0;
            s_d.st     = s_d.locked ? UOCA_S_UCHK : UOCA_S_IDLE;
         end
         UOCA_S_UCHK: begin
            if (s_q.idx < UOCA_UIDX_CRC) begin
               uFeed   = 1'b1;
               uWord   = s_q.otp[s_q.idx];
               s_d.idx = s_q.idx + 2'h1;
            end else begin
               if (uCrc != s_q.otp[UOCA_UIDX_CRC][7:0]) begin
                  s_d.uErrN = 1'b0;
               end
               s_d.st = UOCA_S_IDLE;
            end
         end
         default: begin
            s_d.st = UOCA_S_IDLE;
         end
      endcase

      if (cmd.valid && (cmd.op != UOCA_OP_NOP)) begin
         s_d.rsp.valid = 1'b1;
         unique case (cmd.op)
            UOCA_OP_READ: begin
               s_d.rsp.ok = 1'b1;
               if (isFacAddr(cmd.addr)) begin
                  s_d.rsp.data = s_q.fac[cmd.addr[1:0]];
               end else if (isUserAddr(cmd.addr)) begin
                  s_d.rsp.data = s_q.shadow[uIdx];
               end else if (cmd.addr == UOCA_ADDR_STATUS) begin
                  s_d.rsp.data = stsWord;
               end else begin
                  s_d.rsp.ok = 1'b0;
               end
            end
            UOCA_OP_WRITE: begin
               // factory and status words never take a write
               if (isUserAddr(cmd.addr) && !s_q.locked
                   && (s_q.st == UOCA_S_IDLE)) begin
                  s_d.shadow[uIdx] = cmd.data;
                  s_d.rsp.ok       = 1'b1;
               end
            end
            UOCA_OP_EXEC: begin
               if (!s_q.locked
                   && (s_q.st == UOCA_S_IDLE)) begin
                  s_d.st     = UOCA_S_BURN;
                  s_d.cnt    = 16'h0000;
                  s_d.rsp.ok = 1'b1;
               end
            end
            default: begin
               s_d.rsp.valid = 1'b0;
            end
         endcase
      end

      s_d.busy = (s_d.st != UOCA_S_IDLE);
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q        <= '0;
         s_q.st     <= UOCA_S_FCHK;
         s_q.fac    <= {FAC_CRC_WORD, FAC_CFG_WORD,
                        FACTORY_LOT, FAC_SERIAL_WORD};
         s_q.uErrN  <= 1'b1;
         s_q.fErrN  <= 1'b1;
         s_q.busy   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rsp                = s_q.rsp;
   assign userOtpErrorFlagN  = s_q.uErrN;
   assign factoryErrorFlagN  = s_q.fErrN;
   assign arrayLocked        = s_q.locked;
   assign busy               = s_q.busy;
   assign axisIndicator      = s_q.fac[2][UOCA_FCFG_AXIS];
   assign fullScaleRangeCode =
      s_q.fac[2][UOCA_FCFG_RNG_LSB +: UOCA_RNG_W];

endmodule

// file: sim/uoca_chk_assertions.sv
// port checker for the otp configuration array
// bound to the top module; single ref_clk domain
`timescale 1ns/1ps
module uoca_chk_assertions
   import uoca_pkg::*;
#(
   parameter logic       FACTORY_AXIS  = 1'b0,
   parameter logic [2:0] FACTORY_RANGE = 3'h0
)
(
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_b,
   // command link
   input wire uoca_cmd_s  cmd,
   input wire uoca_rsp_s  rsp,
   // status and properties
   input wire logic       userOtpErrorFlagN,
   input wire logic       arrayLocked,
   input wire logic       busy,
   input wire logic       axisIndicator,
   input wire logic [2:0] fullScaleRangeCode,
   // self-test
   input wire logic       selftestRun,
   input wire logic       selftestRetry,
   input wire logic       sensorErrorMsg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   chk_rsp_answer: assert property (cmd.valid &&
      cmd.op != UOCA_OP_NOP |=> rsp.valid)
      else $error("no answer after command");
   chk_rsp_cause: assert property (rsp.valid |->
      $past(cmd.valid) && $past(cmd.op) != UOCA_OP_NOP)
      else $error("answer without command");
   chk_factory_refused: assert property (cmd.valid &&
      cmd.op == UOCA_OP_WRITE &&
      !(cmd.addr inside {[UOCA_ADDR_UCFG2:UOCA_ADDR_UCRC]}) |=> !rsp.ok)
      else $error("write outside user words accepted");
   chk_locked_refused: assert property (arrayLocked && cmd.valid &&
      cmd.op inside {UOCA_OP_WRITE, UOCA_OP_EXEC} |=> !rsp.ok)
      else $error("locked array accepted programming");
   chk_uerr_sticky: assert property (!userOtpErrorFlagN
      |=> !userOtpErrorFlagN) else $error("user error flag released");
   chk_uerr_after_lock: assert property ($fell(userOtpErrorFlagN)
      |-> arrayLocked) else $error("user check without lock");
   chk_lock_sticky: assert property (arrayLocked |=> arrayLocked)
      else $error("lock released");
   chk_exec_busy: assert property (cmd.valid &&
      cmd.op == UOCA_OP_EXEC && !busy && !arrayLocked
      |=> rsp.ok && busy ##[1:200] !busy)
      else $error("execute not run to completion");
   chk_factory_props: assert property (
      axisIndicator == FACTORY_AXIS && fullScaleRangeCode == FACTORY_RANGE)
      else $error("factory properties wrong");
   chk_retry_pulse: assert property (selftestRetry |=>
      !selftestRetry && !sensorErrorMsg) else $error("retry pulse too long");
   chk_error_ends: assert property ($rose(sensorErrorMsg)
      |-> !selftestRun) else $error("error while self-test runs");
endmodule

bind uoca_user_otp_config_array uoca_chk_assertions #(
   .FACTORY_AXIS (FACTORY_AXIS),
   .FACTORY_RANGE(FACTORY_RANGE)
) u_uoca_chk_assertions (
   .ref_clk(ref_clk), .rst_b(rst_b), .cmd(cmd), .rsp(rsp),
   .userOtpErrorFlagN(userOtpErrorFlagN), .arrayLocked(arrayLocked),
   .busy(busy), .axisIndicator(axisIndicator),
   .fullScaleRangeCode(fullScaleRangeCode), .selftestRun(selftestRun),
   .selftestRetry(selftestRetry), .sensorErrorMsg(sensorErrorMsg)
);

// file: sim/uoca_ecu_model.sv
// behavioural psi5 receiver issuing decoded commands to the array
// assumes one command in flight, answer one cycle after it is taken
`timescale 1ns/1ps
module uoca_ecu_model
   import uoca_pkg::*;
(
   // clock
   input  wire logic      ref_clk,
   // link side of the array
   output uoca_cmd_s      cmd,
   input  wire uoca_rsp_s rsp
);
   initial cmd = '0;

   // every access goes over the link; execute burns whatever lock is set
   task automatic xfer(input uoca_op_e op, input logic [3:0] a,
                       input logic [15:0] d, output logic ok,
                       output logic [15:0] q);
      @(posedge ref_clk);
      cmd <= '{valid: 1'b1, op: op, addr: a, data: d};
      @(posedge ref_clk);
      cmd <= '0;
      #1;
      // a missing answer must never look like a refusal
      ok = (rsp.valid === 1'b1) ? rsp.ok : 1'bx;
      q = rsp.data;
   endtask
endmodule

// file: sim/tb_top.sv
// self-checking bench for the otp configuration array
// assumes the ecu model and the bound port checker
`timescale 1ns/1ps
module tb_top;
   import uoca_pkg::*;
   localparam int          BURN = 4;
   localparam int          LIM  = 3;
   localparam logic [12:0] SER  = 13'h0001;
   localparam logic [15:0] LOT  = 16'h0001;
   localparam logic        AXIS = 1'b1;
   localparam logic [2:0]  FULL_SCALE_RANGE_CODE  = 3'h5;

   logic        ref_clk = 1'b0;
   logic        rst_b   = 1'b0;
   logic        stStart = 1'b0;
   logic        stValid = 1'b0;
   logic        stPass  = 1'b0;
   uoca_cmd_s   cmd;
   uoca_rsp_s   rsp;
   logic        uErrN, fErrN, locked, busy, axis, run, retry, sErr;
   logic [2:0]  full_scale_range_code;
   logic        ok;
   logic [15:0] q, w4, w5;
   int          n_fail = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          nRetry = 0;

   always #5 ref_clk = ~ref_clk;

   uoca_ecu_model u_uoca_ecu_model (.ref_clk(ref_clk), .cmd(cmd), .rsp(rsp));

   uoca_user_otp_config_array #(.FACTORY_SERIAL(SER), .FACTORY_LOT(LOT),
      .FACTORY_AXIS(AXIS), .FACTORY_RANGE(FULL_SCALE_RANGE_CODE),
      .SELFTEST_RETRY_LIMIT(LIM), .BURN_CYCLES(BURN)
   ) u_uoca_user_otp_config_array (
      .ref_clk(ref_clk), .rst_b(rst_b), .cmd(cmd), .rsp(rsp),
      .userOtpErrorFlagN(uErrN), .factoryErrorFlagN(fErrN),
      .arrayLocked(locked), .busy(busy), .axisIndicator(axis),
      .fullScaleRangeCode(full_scale_range_code), .selftestStart(stStart),
      .selftestResultValid(stValid), .selftestPass(stPass),
      .selftestRun(run), .selftestRetry(retry), .sensorErrorMsg(sErr));

   task automatic report_and_stop();
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (retry === 1'b1)
         nRetry++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   function automatic logic [7:0] crc8(logic [15:0] a, logic [15:0] b);
      logic [31:0] s;
      logic [7:0]  r;
      s = {a, b};
      r = UOCA_CRC_INIT;
      for (int i = 31; i >= 0; i--)
         r = {r[6:0], 1'b0} ^ ((r[7] ^ s[i]) ? UOCA_CRC_POLY : 8'h00);
      return r;
   endfunction

   function automatic logic [15:0] expRead(logic [3:0] a);
      case (a)
         4'h0: return {3'h0, SER};
         4'h1: return LOT;
         4'h2: return {11'h0, AXIS, 1'b0, FULL_SCALE_RANGE_CODE};
         // status of an idle, unlocked, error-free array
         4'h7: return (16'h1 << UOCA_STS_UERR_N) |
                      (16'h1 << UOCA_STS_FERR_N);
         default: return 16'h0;
      endcase
   endfunction

   // 17 bits so that an ok flag and a full data word fit together
   task automatic chk(string name, logic [16:0] seen, logic [16:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", name, exp, seen);
      end
   endtask

   task automatic xf(uoca_op_e op, logic [3:0] a, logic [15:0] d);
      u_uoca_ecu_model.xfer(op, a, d, ok, q);
   endtask

   task automatic doReset();
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (20) @(posedge ref_clk);
      chk("rst", {rsp.valid, uErrN, locked, busy}, 16'h5);
      rst_b <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk("idle", {busy, fErrN, uErrN}, 16'h3);
   endtask

   task automatic burn(int exp);
      int n;
      n = 0;
      xf(UOCA_OP_EXEC, 4'h0, 16'h0);
      chk("exec ok", ok, 1'b1);
      while (busy === 1'b1 && n < 500) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("burn len", n[15:0], exp[15:0]);
   endtask

   task automatic stPulse(logic p);
      @(posedge ref_clk);
      stValid <= 1'b1;
      stPass  <= p;
      @(posedge ref_clk);
      stValid <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic stGo();
      @(posedge ref_clk);
      stStart <= 1'b1;
      @(posedge ref_clk);
      stStart <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   initial begin
      void'($urandom(98));
      doReset();
      chk("props", {axis, full_scale_range_code}, {AXIS, FULL_SCALE_RANGE_CODE});
      for (int a = 0; a < 16; a++) begin
         xf(UOCA_OP_READ, a[3:0], 16'h0);
         if (a != 3)
            chk("read", {ok, q}, {a < 8, expRead(a[3:0])});
      end
      for (int a = 0; a < 4; a++) begin
         xf(UOCA_OP_WRITE, a[3:0], 16'($urandom()));
         chk("fac wr", ok, 1'b0);
         xf(UOCA_OP_READ, a[3:0], 16'h0);
         if (a != 3)
            chk("fac keep", q, expRead(a[3:0]));
      end
      chk("fac err", fErrN, 1'b1);
      w4 = 16'($urandom()) & 16'h7fff;
      w5 = 16'($urandom());
      xf(UOCA_OP_WRITE, 4'h4, w4);
      chk("wr4", ok, 1'b1);
      xf(UOCA_OP_WRITE, 4'h5, w5);
      burn(BURN + 1);
      xf(UOCA_OP_READ, 4'h4, 16'h0);
      chk("ucfg2", {locked, q}, {1'b0, w4});
      q = 16'($urandom()) | 16'h8000;
      w4 = w4 | q;
      xf(UOCA_OP_WRITE, 4'h4, q);
      xf(UOCA_OP_WRITE, 4'h6, {8'h0, crc8(w4, w5)});
      burn(BURN + 4);
      xf(UOCA_OP_READ, 4'h7, 16'h0);
      chk("locked sts", q, 16'h0007);
      xf(UOCA_OP_READ, 4'h4, 16'h0);
      chk("lock burnt", q, w4);
      xf(UOCA_OP_WRITE, 4'h5, ~w5);
      chk("lock wr", ok, 1'b0);
      xf(UOCA_OP_EXEC, 4'h0, 16'h0);
      chk("lock exec", {ok, busy}, 16'h0);
      xf(UOCA_OP_READ, 4'h5, 16'h0);
      chk("lock keep", q, w5);
      doReset();
      w4 = 16'($urandom()) | 16'h8000;
      w5 = 16'($urandom());
      xf(UOCA_OP_WRITE, 4'h4, w4);
      xf(UOCA_OP_WRITE, 4'h5, w5);
      xf(UOCA_OP_WRITE, 4'h6, {8'h0, crc8(w4, w5) ^ 8'h01});
      burn(BURN + 4);
      repeat (10) @(posedge ref_clk);
      xf(UOCA_OP_READ, 4'h7, 16'h0);
      chk("uerr sts", {uErrN, q}, {1'b0, 16'h0006});
      doReset();
      chk("uerr clr", uErrN, 1'b1);
      stGo();
      chk("st run", {run, sErr}, 16'h2);
      nRetry = 0;
      for (int i = 0; i <= LIM; i++)
         stPulse(1'b0);
      chk("st fail", {nRetry[7:0], run, sErr}, {LIM[7:0], 2'b01});
      stGo();
      stPulse(1'b1);
      chk("st pass", {run, sErr, nRetry[7:0]}, {2'b00, LIM[7:0]});
      report_and_stop();
   end
endmodule
